// *** logic/bpsm_pin_sync.sv ***
// Purpose: Three-stage synchroniser for asynchronous pins
// Assumes: Pins idle high after power-on
// Notes:   Output moves only when stages two and three agree
`default_nettype none
module bpsm_pin_sync #(
    parameter int W = 2
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output var  logic [W-1:0] level_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);

    initial if (W < 1) $error("bpsm_pin_sync: W must be positive");

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_reg  <= '1;
            s2_reg  <= '1;
            s3_reg  <= '1;
            level_o <= '1;
        end else begin
            s1_reg  <= pin_i;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            level_o <= (agree & s3_reg) | (~agree & level_o);
        end
    end
endmodule : bpsm_pin_sync
`default_nettype wire

// *** logic/bpsm_pkg.sv ***
// Purpose: Shared constants of the bridge power state manager
// Assumes: 250 MHz core clock, 32-bit configuration words
// Notes:   Offsets are configuration byte addresses
`default_nettype none
package bpsm_pkg;
    localparam logic [7:0]  OFS_PWR_CAP_HDR   = 8'h48;
    localparam logic [7:0]  OFS_PWR_STATE_CTL = 8'h4C;
    localparam logic [7:0]  OFS_LINK_CAP_HDR  = 8'h70;
    localparam logic [7:0]  OFS_LINK_CAPS     = 8'h7C;
    localparam logic [7:0]  OFS_LINK_CTL_STS  = 8'h80;
    // Power capability: id 01h, next 50h, D1 and D2 supported, version 3
    localparam logic [31:0] PWR_CAP_HDR_VAL   = 32'h0603_5001;
    // Express capability: id 10h, next 00h, version 2, bridge port type
    localparam logic [31:0] LINK_CAP_HDR_VAL  = 32'h0072_0010;
    localparam int          LCAP_ASPM_LSB     = 10;
    localparam int          LCAP_L0S_LAT_LSB  = 12;
    localparam int          LCAP_L1_LAT_LSB   = 15;
    localparam logic [1:0]  LCAP_ASPM_BOTH    = 2'h3;
    localparam logic [3:0]  LCAP_SPEED_WIDTH  = 4'h1;
    localparam logic [5:0]  LINK_WIDTH_X1     = 6'h01;
    localparam int          PMCSR_PME_EN_BIT  = 8;
    localparam int          PMCSR_PME_STS_BIT = 15;
    localparam int          LCTL_COMMON_CLK   = 6;
    localparam logic [1:0]  DSTATE_D0         = 2'h0;
    localparam logic [1:0]  DSTATE_D3         = 2'h3;
    localparam logic [1:0]  ASPM_L0S          = 2'h1;
    localparam logic [1:0]  ASPM_L1           = 2'h2;
    localparam logic [2:0]  L0S_EXIT_LAT_CODE = 3'h1;
    localparam logic [2:0]  L1_EXIT_LAT_CODE  = 3'h2;
    localparam int          CLK_PERIOD_NS     = 4;
    localparam int          L0S_IDLE_NS       = 7000;
    localparam int          L1_IDLE_NS        = 16000;
    localparam int          L0S_IDLE_CYC      = (L0S_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          L1_IDLE_CYC       = (L1_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          IDLE_CNT_W        = 16;
    typedef enum logic [3:0] {
        LS_L0   = 4'b0001,
        LS_L0S  = 4'b0010,
        LS_L1   = 4'b0100,
        LS_L2L3 = 4'b1000
    } bpsm_link_t;
endpackage : bpsm_pkg
`default_nettype wire

// *** logic/bpsm_top.sv ***
// Purpose: Device power states, clock gating, active link power and reset classes
// Assumes: Config port is a one-cycle strobe interface on the core clock
// Notes:   rst_i stands for the internal power-on reset
//
// Overview of operation
// - Low-power device write starts L1 or L2/L3
// - Reference clock kept in D0, D1, D2
// - Bridge bus clock only in D0
// - Idle link enters L0s/L1 after minimum time
// - Software field permits L0s, L1, or both
// - Exit latencies readable in link capabilities
// - Sticky bits cleared only by global/power-on reset
// - Some bits survive hot reset only
// - Other bits cleared by any reset
// - Power controls 48h, link controls 70h
`default_nettype none
module bpsm_top
    import bpsm_pkg::*;
#(
    parameter int L0S_IDLE_CYCLES = L0S_IDLE_CYC,
    parameter int L1_IDLE_CYCLES  = L1_IDLE_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        global_reset_in_n_i,
    input  wire logic        fundamental_reset_n_i,
    input  wire logic        hot_reset_i,
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [31:0] cfg_wdata_i,
    input  wire logic        tx_pending_i,
    input  wire logic        tx_idle_i,
    input  wire logic        pme_event_i,
    output var  logic [31:0] cfg_rdata_o,
    output var  logic        cfg_rvalid_o,
    output var  logic [3:0]  link_state_o,
    output var  logic        pci_clk_enable_o,
    output var  logic        ref_clock_required_o,
    output var  logic        tx_hold_o
);
    initial begin
        if (L0S_IDLE_CYCLES < 1 || L1_IDLE_CYCLES <= L0S_IDLE_CYCLES || L1_IDLE_CYCLES >= (1 << IDLE_CNT_W))
            $error("bpsm_top: idle cycle counts out of range");
    end

    logic [1:0] pins_sync;
    bpsm_pin_sync #(.W(2)) u_pin_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .pin_i   ({global_reset_in_n_i, fundamental_reset_n_i}),
        .level_o (pins_sync)
    );

    // Three nested reset classes
    wire clr_sticky = rst_i | ~pins_sync[1];
    wire clr_fund   = clr_sticky | ~pins_sync[0];
    wire clr_hot    = clr_fund | hot_reset_i;

    logic [1:0]            dstate_reg;
    logic [1:0]            aspm_ctl_reg;
    logic                  common_clk_reg;
    logic                  pme_en_reg;
    logic                  pme_sts_reg;
    bpsm_link_t            link_reg;
    bpsm_link_t            link_next;
    logic [IDLE_CNT_W-1:0] idle_cnt_reg;

    wire wr_pmcsr = cfg_wr_i && (cfg_addr_i == OFS_PWR_STATE_CTL);
    wire wr_lctl  = cfg_wr_i && (cfg_addr_i == OFS_LINK_CTL_STS);
    wire d0       = (dstate_reg == DSTATE_D0);
    wire d3       = (dstate_reg == DSTATE_D3);
    wire idle     = tx_idle_i && !tx_pending_i;
    // Gate follows the written state, so a D0 rewrite never blips the clock
    wire [1:0] dstate_next = wr_pmcsr ? cfg_wdata_i[1:0] : dstate_reg;
    // Counter lags a cycle; the idle term keeps a fresh request out of L0s/L1
    wire l0s_ok   = idle && aspm_ctl_reg[0] && (32'(idle_cnt_reg) >= 32'(L0S_IDLE_CYCLES));
    wire l1_ok    = idle && aspm_ctl_reg[1] && (32'(idle_cnt_reg) >= 32'(L1_IDLE_CYCLES));

    // PME status: an event in the clearing cycle wins
    wire pme_clr  = wr_pmcsr && cfg_wdata_i[PMCSR_PME_STS_BIT];
    wire pme_next = pme_event_i | (pme_sts_reg & ~pme_clr);

    always_ff @(posedge clock_i) begin
        if (clr_sticky) begin
            pme_sts_reg <= 1'b0;
        end else begin
            pme_sts_reg <= pme_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (clr_fund) begin
            pme_en_reg <= 1'b0;
        end else if (wr_pmcsr) begin
            pme_en_reg <= cfg_wdata_i[PMCSR_PME_EN_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (clr_hot) begin
            dstate_reg     <= DSTATE_D0;
            aspm_ctl_reg   <= 2'h0;
            common_clk_reg <= 1'b0;
        end else begin
            if (wr_pmcsr) dstate_reg <= cfg_wdata_i[1:0];
            if (wr_lctl) aspm_ctl_reg <= cfg_wdata_i[1:0];
            if (wr_lctl) common_clk_reg <= cfg_wdata_i[LCTL_COMMON_CLK];
        end
    end

    // Link state: device state overrides active-state decisions
    always_comb begin
        link_next = link_reg;
        case (link_reg)
            LS_L0: begin
                if (!d0) link_next = d3 ? LS_L2L3 : LS_L1;
                else if (l1_ok) link_next = LS_L1;
                else if (l0s_ok) link_next = LS_L0S;
            end
            LS_L0S: begin
                if (!d0) link_next = d3 ? LS_L2L3 : LS_L1;
                else if (!idle) link_next = LS_L0;
                else if (l1_ok) link_next = LS_L1;
            end
            LS_L1: begin
                if (d3) link_next = LS_L2L3;
                else if (d0 && !idle) link_next = LS_L0;
                else if (d0 && !aspm_ctl_reg[1]) link_next = LS_L0;
            end
            LS_L2L3: begin
                if (d0) link_next = LS_L0;
            end
            default: link_next = LS_L0;
        endcase
    end

    // Counter only runs in L0 and L0s, so a long idle L0s may still reach L1
    always_ff @(posedge clock_i) begin
        if (clr_hot || !idle || link_reg == LS_L1 || link_reg == LS_L2L3) begin
            idle_cnt_reg <= '0;
        end else if (idle_cnt_reg != '1) begin
            idle_cnt_reg <= idle_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (clr_hot) begin
            link_reg             <= LS_L0;
            link_state_o         <= 4'(LS_L0);
            pci_clk_enable_o     <= 1'b1;
            ref_clock_required_o <= 1'b1;
            tx_hold_o            <= 1'b0;
        end else begin
            link_reg             <= link_next;
            link_state_o         <= 4'(link_next);
            pci_clk_enable_o     <= (dstate_next == DSTATE_D0);
            ref_clock_required_o <= (dstate_next != DSTATE_D3);
            tx_hold_o            <= tx_pending_i && (link_next != LS_L0);
        end
    end

    // Read mux: unmapped offsets read zero
    wire [31:0] pmcsr_rd = {16'h0, pme_sts_reg, 6'h0, pme_en_reg, 6'h0, dstate_reg};
    wire [31:0] lcap_rd  = {14'h0, L1_EXIT_LAT_CODE, L0S_EXIT_LAT_CODE, LCAP_ASPM_BOTH,
                            LINK_WIDTH_X1, LCAP_SPEED_WIDTH};
    wire [31:0] lctl_rd  = {6'h0, LINK_WIDTH_X1, LCAP_SPEED_WIDTH, 9'h0,
                            common_clk_reg, 4'h0, aspm_ctl_reg};
    wire [31:0] rd_mux   = (cfg_addr_i == OFS_PWR_CAP_HDR)   ? PWR_CAP_HDR_VAL :
                           (cfg_addr_i == OFS_PWR_STATE_CTL) ? pmcsr_rd :
                           (cfg_addr_i == OFS_LINK_CAP_HDR)  ? LINK_CAP_HDR_VAL :
                           (cfg_addr_i == OFS_LINK_CAPS)     ? lcap_rd :
                           (cfg_addr_i == OFS_LINK_CTL_STS)  ? lctl_rd : 32'h0;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cfg_rdata_o  <= 32'h0;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rdata_o  <= cfg_rd_i ? rd_mux : 32'h0;
            cfg_rvalid_o <= cfg_rd_i;
        end
    end
endmodule : bpsm_top
`default_nettype wire

// *** tb/bpsm_rc_model.sv ***
// Purpose: Upstream port model driving transmit activity
// Assumes: One transaction per send request
// Notes:   Request held until the link is back in L0
`default_nettype none
module bpsm_rc_model
    import bpsm_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       send_i,
    input  wire logic [3:0] link_state_i,
    output var  logic       tx_pending_o,
    output var  logic       tx_idle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] busy_reg;
    wire        in_l0 = link_state_i == LS_L0;
    assign tx_idle_o = busy_reg == 2'h0;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tx_pending_o <= 1'b0;
            busy_reg     <= 2'h0;
        end else if (send_i) begin
            tx_pending_o <= 1'b1;
        end else if (tx_pending_o && in_l0) begin
            tx_pending_o <= 1'b0;
            busy_reg     <= 2'h3;
        end else if (busy_reg != 2'h0) begin
            busy_reg <= busy_reg - 2'h1;
        end
    end
endmodule : bpsm_rc_model
`default_nettype wire

// *** tb/bpsm_top_chk.sv ***
// Purpose: Port checker for bpsm_top
// Assumes: Single core clock domain
// Notes:   Helpers track idle run and L0s permit
`default_nettype none
module bpsm_top_chk
    import bpsm_pkg::*;
#(
    parameter int L0S_IDLE_CYCLES = 4,
    parameter int L1_IDLE_CYCLES  = 10
) (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        hot_reset_i,
    input wire logic        cfg_wr_i,
    input wire logic        cfg_rd_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic        tx_pending_i,
    input wire logic        tx_idle_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cfg_rvalid_o,
    input wire logic [3:0]  link_state_o,
    input wire logic        pci_clk_enable_o,
    input wire logic        ref_clock_required_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int   idle_reg;
    logic l0s_ok_reg;
    wire  d_wr = cfg_wr_i && cfg_addr_i == OFS_PWR_STATE_CTL;
    always_ff @(posedge clock_i) begin
        idle_reg <= (rst_i || !tx_idle_i || tx_pending_i) ? 0 : idle_reg + 1;
        if (rst_i || hot_reset_i) l0s_ok_reg <= 1'b0;
        else if (cfg_wr_i && cfg_addr_i == OFS_LINK_CTL_STS) l0s_ok_reg <= cfg_wdata_i[0];
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    rd_answer_a: assert property (cfg_rvalid_o == $past(cfg_rd_i))
        else $error("read answer misplaced");
    exit_lat_a: assert property (cfg_rd_i && cfg_addr_i == OFS_LINK_CAPS |=>
        cfg_rdata_o[17:12] == {L1_EXIT_LAT_CODE, L0S_EXIT_LAT_CODE}) else $error("exit latency wrong");
    clk_gate_a: assert property ($fell(pci_clk_enable_o) |-> $past(d_wr))
        else $error("bus clock gated without write");
    ref_clock_keep_a: assert property (!ref_clock_required_o |-> !pci_clk_enable_o)
        else $error("reference clock released outside D3");
    d_low_a: assert property (d_wr && cfg_wdata_i[1:0] inside {2'h1, 2'h2} |-> ##2 link_state_o == LS_L1)
        else $error("no L1 after low state");
    d_deep_a: assert property (d_wr && cfg_wdata_i[1:0] == DSTATE_D3 |=> !pci_clk_enable_o ##1
        link_state_o == LS_L2L3) else $error("no L2/L3 after D3");
    idle_time_a: assert property ($rose(link_state_o == LS_L0S) |-> idle_reg >= L0S_IDLE_CYCLES)
        else $error("L0s entered too early");
    l0s_permit_a: assert property ($rose(link_state_o == LS_L0S) |-> l0s_ok_reg)
        else $error("L0s not permitted");
    wake_up_a: assert property (tx_pending_i && pci_clk_enable_o && link_state_o inside {LS_L0S, LS_L1}
        |=> link_state_o == LS_L0) else $error("no return to L0");
    cover property ($rose(link_state_o == LS_L0S));
    cover property ($rose(link_state_o == LS_L1));
    cover property ($rose(link_state_o == LS_L2L3));
endmodule : bpsm_top_chk
bind bpsm_top bpsm_top_chk #(.L0S_IDLE_CYCLES(L0S_IDLE_CYCLES), .L1_IDLE_CYCLES(L1_IDLE_CYCLES)) u_chk (
    .clock_i(clock_i), .rst_i(rst_i), .hot_reset_i(hot_reset_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .tx_pending_i(tx_pending_i), .tx_idle_i(tx_idle_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .link_state_o(link_state_o),
    .pci_clk_enable_o(pci_clk_enable_o), .ref_clock_required_o(ref_clock_required_o));
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for bpsm_top
// Assumes: Idle thresholds cut to 4 and 10 cycles
// Notes:   Inputs move on the falling edge only
`default_nettype none
module tb
    import bpsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] LCAPS = {14'h0, L1_EXIT_LAT_CODE, L0S_EXIT_LAT_CODE, LCAP_ASPM_BOTH, LINK_WIDTH_X1, 4'h1};
    localparam logic [31:0] LCTL  = {6'h0, LINK_WIDTH_X1, LCAP_SPEED_WIDTH, 16'h0};
    logic        clock_i = 1'b0, rst_i = 1'b1, glob_n = 1'b1, frst_n = 1'b1, hot = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, send = 1'b0, pme = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        pend, idle, rvalid, clk_en, ref_req, hold;
    logic [3:0]  link;
    int          num_errors = 0;
    int          compares = 0;
    always #2 clock_i = ~clock_i;
    bpsm_top #(.L0S_IDLE_CYCLES(4), .L1_IDLE_CYCLES(10)) DUT (.clock_i(clock_i), .rst_i(rst_i),
        .global_reset_in_n_i(glob_n), .fundamental_reset_n_i(frst_n), .hot_reset_i(hot), .cfg_wr_i(wr),
        .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_wdata_i(wdata), .tx_pending_i(pend), .tx_idle_i(idle),
        .pme_event_i(pme), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .link_state_o(link),
        .pci_clk_enable_o(clk_en), .ref_clock_required_o(ref_req), .tx_hold_o(hold));
    bpsm_rc_model u_rc (.clock_i(clock_i), .rst_i(rst_i), .send_i(send), .link_state_i(link),
        .tx_pending_o(pend), .tx_idle_o(idle));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clock_i);
        {wr, addr, wdata} = {1'b1, a, d};
        @(negedge clock_i);
        wr = 1'b0;
    endtask : cfg_wr
    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clock_i);
        {rd, addr} = {1'b1, a};
        @(negedge clock_i);
        rd = 1'b0;
        chk({rvalid, rdata}, {1'b1, exp});
    endtask : cfg_rd
    task automatic kick;
        logic seen = 1'b0;
        @(negedge clock_i);
        send = 1'b1;
        @(negedge clock_i);
        send = 1'b0;
        repeat (4) begin
            @(negedge clock_i);
            seen |= (link === LS_L0) && (pend === 1'b0);
        end
        chk({31'h0, seen}, 32'h1);
    endtask : kick
    task automatic hold_low(ref logic pin);
        @(negedge clock_i);
        pin = 1'b0;
        repeat (6) @(negedge clock_i);
        pin = 1'b1;
        repeat (6) @(negedge clock_i);
    endtask : hold_low
    task automatic t_regs;
        cfg_rd(OFS_PWR_CAP_HDR, PWR_CAP_HDR_VAL);
        cfg_rd(OFS_LINK_CAP_HDR, LINK_CAP_HDR_VAL);
        cfg_rd(OFS_LINK_CAPS, LCAPS);
        cfg_wr(OFS_LINK_CAPS, 32'hFFFF_FFFF);
        cfg_rd(OFS_LINK_CAPS, LCAPS);
        cfg_wr(8'h00, 32'hFFFF_FFFF);
        cfg_rd(8'h00, 32'h0);
    endtask : t_regs
    task automatic t_dstate;
        for (int d = 1; d < 4; d++) begin
            cfg_wr(OFS_PWR_STATE_CTL, 32'(d));
            repeat (2) @(negedge clock_i);
            chk({25'h0, link, clk_en, ref_req, hold}, {25'h0, (d == 3) ? LS_L2L3 : LS_L1, 1'b0, d != 3, 1'b0});
            // A request in a low state must wait for L0
            send = 1'b1;
            @(negedge clock_i);
            send = 1'b0;
            @(negedge clock_i);
            chk({63'h0, hold}, 64'h1);
            cfg_wr(OFS_PWR_STATE_CTL, 32'(DSTATE_D0));
            repeat (3) @(negedge clock_i);
            chk({25'h0, link, clk_en, ref_req, hold}, {25'h0, LS_L0, 3'b110});
        end
    endtask : t_dstate
    task automatic t_aspm;
        logic [3:0] exp_st [4] = '{LS_L0, LS_L0S, LS_L1, LS_L1};
        for (int c = 0; c < 4; c++) begin
            cfg_wr(OFS_LINK_CTL_STS, 32'(c));
            kick();
            repeat (22) @(negedge clock_i);
            chk({28'h0, link}, {28'h0, exp_st[c]});
            kick();
        end
    endtask : t_aspm
    task automatic t_resets;
        cfg_wr(OFS_PWR_STATE_CTL, 32'h0000_0101);
        @(negedge clock_i);
        pme = 1'b1;
        @(negedge clock_i);
        {pme, hot} = 2'b01;
        @(negedge clock_i);
        hot = 1'b0;
        cfg_rd(OFS_PWR_STATE_CTL, 32'h0000_8100);
        cfg_rd(OFS_LINK_CTL_STS, LCTL);
        hold_low(frst_n);
        cfg_rd(OFS_PWR_STATE_CTL, 32'h0000_8000);
        hold_low(glob_n);
        cfg_rd(OFS_PWR_STATE_CTL, 32'h0);
    endtask : t_resets
    task automatic close_out;
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        t_regs();
        t_dstate();
        t_aspm();
        t_resets();
        close_out();
    end
    initial begin
        #20000;
        num_errors++;
        close_out();
    end
endmodule : tb
`default_nettype wire
